// file: hw/hcpo_defines.vh
// Operation
// - 3-bit protocol code; 4-7 reserved
// - select 0: no maximum length check
// - select 1: limit from first maximum value
// - select 2: second limit; 3 reserved
// - fcs bit 0: strip rx fcs, append tx
// - fcs bit 1: keep rx fcs, no tx fcs
// - non-fcs: no too-short check, maximum length check as selected
// - ss7 threshold crossing interrupt unless masked
// - ss7 error increment interrupt unless masked
// - ss7 error decrement interrupt unless masked
// - ss7 duplicate: interrupt, discard second message
// - duplicate masked: no interrupt, still discard
// - abort, idle change, too-short interrupt unless masked
`ifndef HCPO_DEFINES_VH
`define HCPO_DEFINES_VH
// register byte offsets
`define HCPO_CFG_ADDR 8'h00
`define HCPO_LIMIT_ADDR 8'h04
`define HCPO_THRESH_ADDR 8'h08
`define HCPO_STATUS_ADDR 8'h0C
`define HCPO_CLEAR_ADDR 8'h10
`define HCPO_ENABLE_ADDR 8'h14
`define HCPO_MONITOR_ADDR 8'h18
// configuration fields
`define HCPO_PROTO_HI 14
`define HCPO_PROTO_LO 12
`define HCPO_LEN_SEL_HI 11
`define HCPO_LEN_SEL_LO 10
`define HCPO_FCS_BIT 9
`define HCPO_MSK_THR_BIT 8
`define HCPO_MSK_INC_BIT 7
`define HCPO_MSK_DEC_BIT 6
`define HCPO_MSK_DUP_BIT 5
`define HCPO_MSK_LINE_BIT 4
`define HCPO_CFG_RESET 32'h0000_0000
`define HCPO_CFG_MASK 32'h0000_7FF0
// protocol codes
`define HCPO_PROTO_TRANSP 3'h0
`define HCPO_PROTO_SS7 3'h1
`define HCPO_PROTO_FCS16 3'h2
`define HCPO_PROTO_FCS32 3'h3
// limit register: two 14-bit maximum lengths
`define HCPO_LIM1_HI 13
`define HCPO_LIM1_LO 0
`define HCPO_LIM2_HI 29
`define HCPO_LIM2_LO 16
`define HCPO_LIMIT_RESET 32'h0000_0000
// error monitor threshold reset
`define HCPO_THRESH_RESET 8'h40
// status / enable bit positions
`define HCPO_ST_THR 0
`define HCPO_ST_INC 1
`define HCPO_ST_DEC 2
`define HCPO_ST_DUP 3
`define HCPO_ST_ABT 4
`define HCPO_ST_IDLE 5
`define HCPO_ST_SHORT 6
`define HCPO_ST_LONG 7
`define HCPO_ST_W 8
// least data bytes of a formatted message
`define HCPO_MIN_DATA 15'h0002
`endif

// file: hw/hcpo_top.v
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "hcpo_defines.vh"
module hcpo_top
(
  input wire CLOCK,
  input wire RESET,
  // wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // receive byte stream from the deformatter, fcs included
  input wire [7:0] RX_BYTE,
  input wire RX_VALID,
  input wire RX_LAST,
  // line state levels from the receive flag detector
  input wire RX_ABORT,
  input wire RX_IDLE,
  // signal unit error monitor pulses
  input wire SU_ERROR,
  input wire SU_GOOD,
  // data toward shared memory
  output reg [7:0] MEM_BYTE,
  output reg MEM_VALID,
  output reg MEM_END,
  output reg MEM_DISCARD,
  // transmit side
  input wire TX_LAST,
  output reg TX_FCS_APPEND,
  output wire IRQ
);

// software visible state
reg [31:0] cfg; // channel options
reg [31:0] limits; // two maximum lengths
reg [7:0] thresh; // error count threshold
reg [`HCPO_ST_W-1:0] status; // sticky events
reg [`HCPO_ST_W-1:0] enable; // interrupt enables
reg [7:0] err_count; // signal unit error count

// receive message state
reg [7:0] pipe0, pipe1, pipe2, pipe3; // fcs holdback stage
reg [14:0] count; // bytes taken in this message
reg [15:0] sig; // running signature of message
reg [15:0] prev_sig; // signature of previous message
reg [14:0] prev_len; // length of previous message
reg prev_ok; // previous message is comparable
reg abort_q, idle_q; // line state last cycle

// decoded configuration
wire [2:0] proto = cfg[`HCPO_PROTO_HI:`HCPO_PROTO_LO];
wire [1:0] max_length_select = cfg[`HCPO_LEN_SEL_HI:`HCPO_LEN_SEL_LO];
wire fcs_pass = cfg[`HCPO_FCS_BIT];
wire mask_error_threshold_irq = cfg[`HCPO_MSK_THR_BIT];
wire mask_error_increment_irq = cfg[`HCPO_MSK_INC_BIT];
wire mask_error_decrement_irq = cfg[`HCPO_MSK_DEC_BIT];
wire mask_duplicate_filter_irq = cfg[`HCPO_MSK_DUP_BIT];
wire mask_line_state_irq = cfg[`HCPO_MSK_LINE_BIT];
wire [13:0] max_frame_limit_one = limits[`HCPO_LIM1_HI:`HCPO_LIM1_LO];
wire [13:0] max_frame_limit_two = limits[`HCPO_LIM2_HI:`HCPO_LIM2_LO];

// reserved codes 4-7 behave as transparent
wire is_ss7 = (proto == `HCPO_PROTO_SS7);
wire is_hdlc = (proto == `HCPO_PROTO_SS7) || (proto == `HCPO_PROTO_FCS16)
  || (proto == `HCPO_PROTO_FCS32);

// number of fcs bytes held back from memory
reg [2:0] strip_n;
always @*
begin
  if (!is_hdlc || fcs_pass)
  begin
    strip_n = 3'h0;
  end
  else if (proto == `HCPO_PROTO_FCS32)
  begin
    strip_n = 3'h4;
  end
  else
  begin
    strip_n = 3'h2;
  end
end

// signature step, used for both live and stored messages
function [15:0] hcpo_sig;
  input [15:0] s;
  input [7:0] b;
  integer i;
  reg [15:0] t;
  begin
    t = s ^ {b, 8'h00};
    for (i = 0; i < 8; i = i + 1)
    begin
      t = t[15] ? ({t[14:0], 1'b0} ^ 16'h1021) : {t[14:0], 1'b0};
    end
    hcpo_sig = t;
  end
endfunction

// byte that leaves the holdback stage this cycle
reg [7:0] out_byte;
always @*
begin
  case (strip_n)
    3'h2: out_byte = pipe1;
    3'h4: out_byte = pipe3;
    default: out_byte = RX_BYTE;
  endcase
end

// receive bookkeeping per byte and at message end
wire rx_take = RX_VALID;
wire rx_end = RX_VALID && RX_LAST;
wire [14:0] total = count + 15'h0001; // bytes including this one
wire [14:0] data_len = total - {12'h000, strip_n}; // length without fcs
wire emit = rx_take && (count >= {12'h000, strip_n});
wire [15:0] next_sig = emit ? hcpo_sig(sig, out_byte) : sig;

// maximum length selection; 3 is reserved and acts as 2
reg [14:0] limit_sel;
reg check_len;
always @*
begin
  case (max_length_select)
    2'h0:
    begin
      limit_sel = 15'h0000;
      check_len = 1'b0;
    end
    2'h1:
    begin
      limit_sel = {1'b0, max_frame_limit_one};
      check_len = 1'b1;
    end
    default:
    begin
      limit_sel = {1'b0, max_frame_limit_two};
      check_len = 1'b1;
    end
  endcase
end

// end-of-message classification
wire too_long = rx_end && check_len && (data_len > limit_sel);
// too-short check only with fcs present and framing on
wire too_short = rx_end && is_hdlc && !fcs_pass
  && (total < ({12'h000, strip_n} + `HCPO_MIN_DATA));
// duplicate filter only in ss7; second copy is always dropped
wire dup = rx_end && is_ss7 && prev_ok && (next_sig == prev_sig)
  && (data_len == prev_len);

// error monitor events, ss7 only
wire su_inc = is_ss7 && SU_ERROR && !SU_GOOD && (err_count != 8'hFF);
wire su_dec = is_ss7 && SU_GOOD && !SU_ERROR && (err_count != 8'h00);
wire su_cross = su_inc && ((err_count + 8'h01) == thresh);

// line state change events
wire abort_change = RX_ABORT && !abort_q;
wire idle_change = RX_IDLE && !idle_q;

// events gated by the channel masks, too-long ungated
reg [`HCPO_ST_W-1:0] ev;
always @*
begin
  ev = {`HCPO_ST_W{1'b0}};
  ev[`HCPO_ST_THR] = su_cross && !mask_error_threshold_irq;
  ev[`HCPO_ST_INC] = su_inc && !mask_error_increment_irq;
  ev[`HCPO_ST_DEC] = su_dec && !mask_error_decrement_irq;
  ev[`HCPO_ST_DUP] = dup && !mask_duplicate_filter_irq;
  ev[`HCPO_ST_ABT] = abort_change && !mask_line_state_irq;
  ev[`HCPO_ST_IDLE] = idle_change && !mask_line_state_irq;
  ev[`HCPO_ST_SHORT] = too_short && !mask_line_state_irq;
  ev[`HCPO_ST_LONG] = too_long;
end

// wishbone decode
wire wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
wire wb_wr = wb_req && WB_WE_I;

// byte lane merge for writes
function [31:0] hcpo_merge;
  input [31:0] old;
  input [31:0] data;
  input [3:0] sel;
  begin
    hcpo_merge[7:0] = sel[0] ? data[7:0] : old[7:0];
    hcpo_merge[15:8] = sel[1] ? data[15:8] : old[15:8];
    hcpo_merge[23:16] = sel[2] ? data[23:16] : old[23:16];
    hcpo_merge[31:24] = sel[3] ? data[31:24] : old[31:24];
  end
endfunction

// clear strobe from the write-only clear register
wire [`HCPO_ST_W-1:0] clr = (wb_wr && (WB_ADR_I == `HCPO_CLEAR_ADDR)
  && WB_SEL_I[0]) ? WB_DAT_I[`HCPO_ST_W-1:0] : {`HCPO_ST_W{1'b0}};

// register writes and answer, ack one cycle after the request
always @(posedge CLOCK)
begin
  if (RESET)
  begin
    cfg <= `HCPO_CFG_RESET;
    limits <= `HCPO_LIMIT_RESET;
    thresh <= `HCPO_THRESH_RESET;
    enable <= {`HCPO_ST_W{1'b0}};
    WB_ACK_O <= 1'b0;
    WB_DAT_O <= 32'h0000_0000;
  end
  else
  begin
    WB_ACK_O <= wb_req;
    if (wb_wr)
    begin
      case (WB_ADR_I)
        `HCPO_CFG_ADDR:
          cfg <= hcpo_merge(cfg, WB_DAT_I, WB_SEL_I) & `HCPO_CFG_MASK;
        `HCPO_LIMIT_ADDR:
          limits <= hcpo_merge(limits, WB_DAT_I, WB_SEL_I) & 32'h3FFF_3FFF;
        `HCPO_THRESH_ADDR:
          if (WB_SEL_I[0]) thresh <= WB_DAT_I[7:0];
        `HCPO_ENABLE_ADDR:
          if (WB_SEL_I[0]) enable <= WB_DAT_I[`HCPO_ST_W-1:0];
        default: ; // read-only, write-only clear, or unmapped
      endcase
    end
    // read data, zero for unmapped or write-only
    if (wb_req && !WB_WE_I)
    begin
      case (WB_ADR_I)
        `HCPO_CFG_ADDR: WB_DAT_O <= cfg;
        `HCPO_LIMIT_ADDR: WB_DAT_O <= limits;
        `HCPO_THRESH_ADDR: WB_DAT_O <= {24'h00_0000, thresh};
        `HCPO_STATUS_ADDR: WB_DAT_O <= {24'h00_0000, status};
        `HCPO_ENABLE_ADDR: WB_DAT_O <= {24'h00_0000, enable};
        `HCPO_MONITOR_ADDR: WB_DAT_O <= {9'h000, count, err_count};
        default: WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end
end

// sticky status and line state history; a new event wins over a clear
always @(posedge CLOCK)
begin
  if (RESET)
  begin
    status <= {`HCPO_ST_W{1'b0}};
    abort_q <= 1'b0; // idle level of the pin, so no false edge after reset
    idle_q <= 1'b0;
  end
  else
  begin
    status <= (status & ~clr) | ev;
    abort_q <= RX_ABORT;
    idle_q <= RX_IDLE;
  end
end

// level interrupt while an enabled status bit is set
assign IRQ = |(status & enable);

// signal unit error count
always @(posedge CLOCK)
begin
  if (RESET)
  begin
    err_count <= 8'h00;
  end
  else if (!is_ss7)
  begin
    err_count <= 8'h00; // monitor idle outside ss7
  end
  else if (su_inc)
  begin
    err_count <= err_count + 8'h01;
  end
  else if (su_dec)
  begin
    err_count <= err_count - 8'h01;
  end
end

// holdback stage, byte count and signature
always @(posedge CLOCK)
begin
  if (RESET)
  begin
    pipe0 <= 8'h00;
    pipe1 <= 8'h00;
    pipe2 <= 8'h00;
    pipe3 <= 8'h00;
    count <= 15'h0000;
    sig <= 16'hFFFF;
  end
  else if (rx_take)
  begin
    pipe0 <= RX_BYTE;
    pipe1 <= pipe0;
    pipe2 <= pipe1;
    pipe3 <= pipe2;
    // saturate so an endless message cannot wrap the counter
    if (rx_end)
    begin
      count <= 15'h0000;
      sig <= 16'hFFFF;
    end
    else
    begin
      count <= (count == 15'h7FFF) ? count : total;
      sig <= next_sig;
    end
  end
end

// previous message memory for the duplicate filter
always @(posedge CLOCK)
begin
  if (RESET)
  begin
    prev_sig <= 16'h0000;
    prev_len <= 15'h0000;
    prev_ok <= 1'b0;
  end
  else if (!is_ss7)
  begin
    prev_ok <= 1'b0;
  end
  else if (rx_end)
  begin
    // a bad message breaks the chain of identical ones
    prev_sig <= next_sig;
    prev_len <= data_len;
    prev_ok <= !too_long && !too_short;
  end
end

// memory side outputs and transmit fcs request, registered
always @(posedge CLOCK)
begin
  if (RESET)
  begin
    MEM_BYTE <= 8'h00;
    MEM_VALID <= 1'b0;
    MEM_END <= 1'b0;
    MEM_DISCARD <= 1'b0;
    TX_FCS_APPEND <= 1'b0;
  end
  else
  begin
    MEM_VALID <= emit;
    if (emit)
    begin
      MEM_BYTE <= out_byte;
    end
    MEM_END <= rx_end;
    MEM_DISCARD <= dup || too_long || too_short;
    // check sequence follows the last data byte, one cycle later
    TX_FCS_APPEND <= TX_LAST && is_hdlc && !fcs_pass;
  end
end

endmodule // hcpo_top
`default_nettype wire

// file: bench/hcpo_chk.sv
`timescale 1ns/10ps
`default_nettype none
// port-level timing checks of the option block
module hcpo_chk
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic RX_VALID,
  input wire logic RX_LAST,
  input wire logic MEM_VALID,
  input wire logic MEM_END,
  input wire logic MEM_DISCARD,
  input wire logic TX_LAST,
  input wire logic TX_FCS_APPEND
);
  // one domain, so clock and reset are stated once
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  a_ack_next_edge: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  // read data must not drift between reads
  a_rdata_holds: assert property (!$past(WB_CYC_I && WB_STB_I && !WB_WE_I) |-> $stable(WB_DAT_O))
    else $error("read data changed without a read");
  a_fcs_after_last: assert property (TX_FCS_APPEND |-> $past(TX_LAST))
    else $error("check append without last bit");
  a_byte_cause: assert property (MEM_VALID |-> $past(RX_VALID))
    else $error("memory byte without line byte");
  a_end_cause: assert property (MEM_END |-> $past(RX_VALID && RX_LAST))
    else $error("message end without last byte");
  a_end_on_last: assert property (RX_VALID && RX_LAST |=> MEM_END)
    else $error("last byte gave no message end");
  a_discard_at_end: assert property (MEM_DISCARD |-> MEM_END)
    else $error("discard outside message end");
endmodule // hcpo_chk
bind hcpo_top hcpo_chk chk_u (.CLOCK(CLOCK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .RX_VALID(RX_VALID), .RX_LAST(RX_LAST), .MEM_VALID(MEM_VALID), .MEM_END(MEM_END),
  .MEM_DISCARD(MEM_DISCARD), .TX_LAST(TX_LAST), .TX_FCS_APPEND(TX_FCS_APPEND));
`default_nettype wire

// file: bench/hcpo_line_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: deformatter bytes, line state levels, error monitor pulses
module hcpo_line_model
(
  input wire logic clock,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_last,
  output logic rx_abort,
  output logic rx_idle,
  output logic su_error,
  output logic su_good
);
  initial {rx_byte, rx_valid, rx_last, rx_abort, rx_idle, su_error, su_good} = 14'h0;
  // n bytes, check bytes included, back to back
  task send(input int n, input logic [7:0] s);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      rx_byte <= s + 8'(i);
      rx_valid <= 1'b1;
      rx_last <= (i == n - 1);
    end
    @(posedge clock);
    // released line shows no stale byte
    rx_byte <= ~rx_byte;
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask
  // levels stay, pulses last one cycle
  task ev(input logic [3:0] v);
    @(posedge clock);
    {rx_abort, rx_idle, su_error, su_good} <= v;
    @(posedge clock);
    {su_error, su_good} <= 2'b00;
  endtask
endmodule // hcpo_line_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock, reset, cyc, stb, we, ack, tx_last, tx_fcs, irq, disc;
  logic [7:0] adr, rx_byte, mem_byte, exp_b;
  logic [3:0] sel = 4'h0, lanes = 4'hF;
  logic [31:0] wdat, rd, dat_o;
  logic rx_valid, rx_last, rx_abort, rx_idle, su_error, su_good;
  logic mem_valid, mem_end, mem_discard;
  int error_cnt = 0, comparisons = 0, n_mem = 0, cycles = 0;
  initial
  begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  hcpo_top dut_u (.CLOCK(clock), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .RX_BYTE(rx_byte), .RX_VALID(rx_valid), .RX_LAST(rx_last),
    .RX_ABORT(rx_abort), .RX_IDLE(rx_idle), .SU_ERROR(su_error), .SU_GOOD(su_good),
    .MEM_BYTE(mem_byte), .MEM_VALID(mem_valid), .MEM_END(mem_end),
    .MEM_DISCARD(mem_discard), .TX_LAST(tx_last), .TX_FCS_APPEND(tx_fcs), .IRQ(irq));
  hcpo_line_model line_u (.clock(clock), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_abort(rx_abort), .rx_idle(rx_idle), .su_error(su_error),
    .su_good(su_good));
  // memory side monitor and hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      error_cnt++;
      conclude;
    end
    else
    begin
      // bytes reach memory in line order, starting with the first data byte
      if (mem_valid === 1'b1)
      begin
        cmp(mem_byte, 8'(exp_b + n_mem));
        n_mem++;
      end
      if (mem_end === 1'b1) disc = mem_discard;
    end
  end
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // classic single cycle, held until ack is seen
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, lanes};
    do @(posedge clock); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  // send n bytes, expect m bytes to memory and discard flag d
  task msg(input int n, input logic [7:0] s, input int m, input logic d);
    n_mem = 0;
    exp_b = s;
    disc = 1'bx;
    line_u.send(n, s);
    repeat (3) @(posedge clock);
    cmp(n_mem, m);
    cmp(disc, d);
  endtask
  task tx(input logic e);
    @(posedge clock);
    tx_last <= 1'b1;
    @(posedge clock);
    tx_last <= 1'b0;
    #1 cmp(tx_fcs, e);
  endtask
  task t_regs;
    rdchk(8'h00, 32'h0);
    rdchk(8'h08, 32'h0000_0040);
    rdchk(8'h1C, 32'h0);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'h0000_7FF0);
    // lane 1 only: cfg bits 15:8 cleared, threshold needs lane 0
    lanes = 4'h2;
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h0000_0011);
    lanes = 4'hF;
    rdchk(8'h00, 32'h0000_00F0);
    rdchk(8'h08, 32'h0000_0040);
    $display("register test done");
  endtask
  task t_fcs;
    // protocol codes 0 to 4, strip count 0, 2, 2, 4, 0 per code
    for (int p = 0; p < 5; p++)
    begin
      wb(1'b1, 8'h00, {17'h0, p[2:0], 12'h0});
      msg(6, 8'(16 * p), (p == 3) ? 2 : ((p == 1 || p == 2) ? 4 : 6), 1'b0);
    end
    wb(1'b1, 8'h00, 32'h0000_2000);
    tx(1'b1);
    wb(1'b1, 8'h00, 32'h0000_2200);
    msg(4, 8'h60, 4, 1'b0);
    tx(1'b0);
    msg(1, 8'h70, 1, 1'b0);
    $display("check sequence test done");
  endtask
  task t_line;
    wb(1'b1, 8'h00, 32'h0000_2000);
    wb(1'b1, 8'h14, 32'h0000_00FF);
    msg(3, 8'h50, 1, 1'b1);
    rdchk(8'h0C, 32'h0000_0040);
    cmp(irq, 1'b1);
    wb(1'b1, 8'h10, 32'h0000_00FF);
    rdchk(8'h0C, 32'h0);
    cmp(irq, 1'b0);
    line_u.ev(4'b1000);
    rdchk(8'h0C, 32'h0000_0010);
    line_u.ev(4'b1100);
    rdchk(8'h0C, 32'h0000_0030);
    wb(1'b1, 8'h00, 32'h0000_2010);
    wb(1'b1, 8'h10, 32'h0000_00FF);
    line_u.ev(4'b0000);
    line_u.ev(4'b1100);
    rdchk(8'h0C, 32'h0);
    $display("line state test done");
  endtask
  task t_len;
    wb(1'b1, 8'h04, 32'h0003_0002);
    wb(1'b1, 8'h00, 32'h0000_2000);
    msg(6, 8'h11, 4, 1'b0);
    wb(1'b1, 8'h00, 32'h0000_2400);
    msg(5, 8'h21, 3, 1'b1);
    msg(4, 8'h31, 2, 1'b0);
    wb(1'b1, 8'h00, 32'h0000_2800);
    msg(5, 8'h41, 3, 1'b0);
    msg(6, 8'h51, 4, 1'b1);
    $display("length test done");
  endtask
  task t_ss7;
    wb(1'b1, 8'h00, 32'h0000_1000);
    wb(1'b1, 8'h10, 32'h0000_00FF);
    msg(5, 8'h80, 3, 1'b0);
    msg(5, 8'h80, 3, 1'b1);
    rdchk(8'h0C, 32'h0000_0008);
    wb(1'b1, 8'h00, 32'h0000_1020);
    wb(1'b1, 8'h10, 32'h0000_00FF);
    msg(5, 8'h90, 3, 1'b0);
    msg(5, 8'h90, 3, 1'b1);
    rdchk(8'h0C, 32'h0);
    // count 1, 2 (threshold), back to 1
    wb(1'b1, 8'h08, 32'h0000_0002);
    wb(1'b1, 8'h00, 32'h0000_1000);
    line_u.ev(4'b0010);
    line_u.ev(4'b0010);
    line_u.ev(4'b0001);
    rdchk(8'h0C, 32'h0000_0007);
    wb(1'b1, 8'h00, 32'h0000_11C0);
    wb(1'b1, 8'h10, 32'h0000_00FF);
    line_u.ev(4'b0010);
    line_u.ev(4'b0001);
    rdchk(8'h0C, 32'h0);
    wb(1'b1, 8'h00, 32'h0000_2000);
    line_u.ev(4'b0010);
    line_u.ev(4'b0001);
    msg(5, 8'hA0, 3, 1'b0);
    msg(5, 8'hA0, 3, 1'b0);
    rdchk(8'h0C, 32'h0);
    $display("signalling test done");
  endtask
  initial
  begin
    {reset, cyc, stb, we, adr, wdat, tx_last} = {4'b1000, 8'h0, 32'h0, 1'b0};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_fcs;
    t_line;
    t_len;
    t_ss7;
    conclude;
  end
endmodule // testbench
`default_nettype wire
